//--- bridge_legacy_pkg.sv
// Constants and helpers for the legacy decode and system-error forwarding block
package bridge_legacy_pkg;

    // ---------------------------------------------------------------
    // Register port geometry
    // ---------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_COMMAND = 8'h04;
    localparam logic [7:0] OFS_IO_BASE = 8'h10;
    localparam logic [7:0] OFS_IO_LIMIT = 8'h14;
    localparam logic [7:0] OFS_MEM_BASE = 8'h18;
    localparam logic [7:0] OFS_MEM_LIMIT = 8'h1C;
    localparam logic [7:0] OFS_PREF_BASE = 8'h20;
    localparam logic [7:0] OFS_PREF_LIMIT = 8'h24;
    localparam logic [7:0] OFS_BRIDGE_CONTROL = 8'h3C;
    localparam logic [7:0] OFS_ERR_STATUS = 8'h40;
    localparam logic [7:0] OFS_ERR_CONTROL = 8'h44;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int CMD_IO_SPACE_BIT = 0;
    localparam int CMD_MEM_SPACE_BIT = 1;
    localparam int CMD_BUS_MASTER_BIT = 2;
    localparam int CMD_SYSERR_BIT = 8;
    localparam int BC_SYSERR_FWD_BIT = 1;
    localparam int BC_ISA_BIT = 2;
    localparam int BC_VGA_BIT = 3;
    localparam int ST_SERR_LEVEL_BIT = 0;
    localparam int ST_SERR_FWD_BIT = 1;
    localparam int ST_MSG_PENDING_BIT = 2;
    localparam int EC_FATAL_BIT = 0;

    // ---------------------------------------------------------------
    // Reset values and writable masks
    // ---------------------------------------------------------------
    localparam logic [15:0] COMMAND_RESET = 16'h0000;
    localparam logic [15:0] COMMAND_MASK = 16'h0107;
    localparam logic [15:0] BRIDGE_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] BRIDGE_CONTROL_MASK = 16'h000E;
    localparam logic [31:0] WINDOW_BASE_RESET = 32'hFFFF_FFFF;
    localparam logic [31:0] WINDOW_LIMIT_RESET = 32'h0000_0000;
    localparam logic ERR_FATAL_RESET = 1'b0;

    // ---------------------------------------------------------------
    // Legacy address ranges
    // ---------------------------------------------------------------
    localparam logic [31:0] VGA_MEM_LO = 32'h000A_0000;
    localparam logic [31:0] VGA_MEM_HI = 32'h000B_FFFF;
    localparam logic [9:0] VGA_IO_A_LO = 10'h3B0;
    localparam logic [9:0] VGA_IO_A_HI = 10'h3BB;
    localparam logic [9:0] VGA_IO_B_LO = 10'h3C0;
    localparam logic [9:0] VGA_IO_B_HI = 10'h3DF;
    localparam logic [15:0] IO_LOW_REGION_TOP = 16'h0000;

    // Inclusive 32-bit range check, used for every window except the VGA I/O ranges
    function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                      input logic [31:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    function automatic logic in_range10(input logic [9:0] a, input logic [9:0] lo,
                                        input logic [9:0] hi);
        in_range10 = (a >= lo) && (a <= hi);
    endfunction : in_range10

endpackage : bridge_legacy_pkg

//--- legacy_addr_decode.sv
// Address classification for one transaction against legacy and programmed windows
`timescale 1ns/100ps
module legacy_addr_decode (
    input wire logic [31:0] addr,
    input wire logic [31:0] ioBase,
    input wire logic [31:0] ioLimit,
    input wire logic [31:0] memBase,
    input wire logic [31:0] memLimit,
    input wire logic [31:0] prefBase,
    input wire logic [31:0] prefLimit,
    output logic vgaMemRange,
    output logic vgaIoRange,
    output logic ioWindowHit,
    output logic memWindowHit,
    output logic ioLowRegion,
    output logic isaUpper768
);
    import bridge_legacy_pkg::*;

    logic upperZero;
    logic [9:0] lowTen;

    assign upperZero = (addr[31:16] == IO_LOW_REGION_TOP);
    assign lowTen = addr[9:0];
    assign vgaMemRange = in_range(addr, VGA_MEM_LO, VGA_MEM_HI);
    // Bits [15:10] never enter the compare, so every alias below 10000h matches
    assign vgaIoRange = upperZero &&
                        (in_range10(lowTen, VGA_IO_A_LO, VGA_IO_A_HI) ||
                         in_range10(lowTen, VGA_IO_B_LO, VGA_IO_B_HI));
    assign ioWindowHit = in_range(addr, ioBase, ioLimit);
    assign memWindowHit = in_range(addr, memBase, memLimit) ||
                          in_range(addr, prefBase, prefLimit);
    assign ioLowRegion = upperZero;
    // Offsets 100h..3FFh of each 1-KB block are the upper 768 bytes
    assign isaUpper768 = (addr[9:8] != 2'b00);

endmodule : legacy_addr_decode

//--- bridge_legacy_decode_serr_fwd.sv
// Legacy VGA/ISA forwarding decode and secondary system-error forwarding
`timescale 1ns/100ps
module bridge_legacy_decode_serr_fwd (
    input wire logic core_clk,
    input wire logic rstn,
    // Register port
    input wire logic [bridge_legacy_pkg::ADDR_W-1:0] regAddr,
    input wire logic [bridge_legacy_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [bridge_legacy_pkg::DATA_W-1:0] regRdata,
    // Primary-side (downstream) request
    input wire logic priValid,
    input wire logic priIsIo,
    input wire logic [31:0] priAddr,
    output logic priClaim,
    // Secondary-side (upstream) request
    input wire logic secValid,
    input wire logic secIsIo,
    input wire logic [31:0] secAddr,
    output logic secClaim,
    // Secondary system-error pin
    input wire logic secSerr_n,
    // Error message to the link
    output logic errMsgReq,
    output logic errMsgFatal,
    input wire logic errMsgAck
);
    import bridge_legacy_pkg::*;

    // ---------------------------------------------------------------
    // Configuration registers
    // ---------------------------------------------------------------
    logic [15:0] command;
    logic [15:0] bridgeControl;
    logic [31:0] ioBase;
    logic [31:0] ioLimit;
    logic [31:0] memBase;
    logic [31:0] memLimit;
    logic [31:0] prefBase;
    logic [31:0] prefLimit;
    logic errFatal;
    logic serrForwarded;

    logic ioSpaceEnable;
    logic memorySpaceEnable;
    logic busMasterEnable;
    logic commandSyserrEnable;
    logic secondarySyserrForwardEnable;
    logic isaEnable;
    logic vgaEnable;

    assign ioSpaceEnable = command[CMD_IO_SPACE_BIT];
    assign memorySpaceEnable = command[CMD_MEM_SPACE_BIT];
    assign busMasterEnable = command[CMD_BUS_MASTER_BIT];
    assign commandSyserrEnable = command[CMD_SYSERR_BIT];
    assign secondarySyserrForwardEnable = bridgeControl[BC_SYSERR_FWD_BIT];
    assign isaEnable = bridgeControl[BC_ISA_BIT];
    assign vgaEnable = bridgeControl[BC_VGA_BIT];

    // ---------------------------------------------------------------
    // Register write decode
    // ---------------------------------------------------------------
    logic wrCommand;
    logic wrBridgeControl;
    logic wrIoBase;
    logic wrIoLimit;
    logic wrMemBase;
    logic wrMemLimit;
    logic wrPrefBase;
    logic wrPrefLimit;
    logic wrErrStatus;
    logic wrErrControl;

    assign wrCommand = regWr && (regAddr == OFS_COMMAND);
    assign wrBridgeControl = regWr && (regAddr == OFS_BRIDGE_CONTROL);
    assign wrIoBase = regWr && (regAddr == OFS_IO_BASE);
    assign wrIoLimit = regWr && (regAddr == OFS_IO_LIMIT);
    assign wrMemBase = regWr && (regAddr == OFS_MEM_BASE);
    assign wrMemLimit = regWr && (regAddr == OFS_MEM_LIMIT);
    assign wrPrefBase = regWr && (regAddr == OFS_PREF_BASE);
    assign wrPrefLimit = regWr && (regAddr == OFS_PREF_LIMIT);
    assign wrErrStatus = regWr && (regAddr == OFS_ERR_STATUS);
    assign wrErrControl = regWr && (regAddr == OFS_ERR_CONTROL);

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            command <= COMMAND_RESET;
            bridgeControl <= BRIDGE_CONTROL_RESET;
            errFatal <= ERR_FATAL_RESET;
        end else begin
            if (wrCommand) begin
                command <= regWdata[15:0] & COMMAND_MASK;
            end
            if (wrBridgeControl) begin
                bridgeControl <= regWdata[15:0] & BRIDGE_CONTROL_MASK;
            end
            if (wrErrControl) begin
                errFatal <= regWdata[EC_FATAL_BIT];
            end
        end
    end

    // Base above limit disables a window, so reset leaves all windows closed
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ioBase <= WINDOW_BASE_RESET;
            ioLimit <= WINDOW_LIMIT_RESET;
            memBase <= WINDOW_BASE_RESET;
            memLimit <= WINDOW_LIMIT_RESET;
            prefBase <= WINDOW_BASE_RESET;
            prefLimit <= WINDOW_LIMIT_RESET;
        end else begin
            if (wrIoBase) begin
                ioBase <= regWdata;
            end
            if (wrIoLimit) begin
                ioLimit <= regWdata;
            end
            if (wrMemBase) begin
                memBase <= regWdata;
            end
            if (wrMemLimit) begin
                memLimit <= regWdata;
            end
            if (wrPrefBase) begin
                prefBase <= regWdata;
            end
            if (wrPrefLimit) begin
                prefLimit <= regWdata;
            end
        end
    end

    // ---------------------------------------------------------------
    // Primary-to-secondary decode
    // ---------------------------------------------------------------
    logic priVgaMem;
    logic priVgaIo;
    logic priIoWin;
    logic priMemWin;
    logic priIoLow;
    logic priUpper768;

    legacy_addr_decode u_pri_decode (
        .addr(priAddr),
        .ioBase(ioBase),
        .ioLimit(ioLimit),
        .memBase(memBase),
        .memLimit(memLimit),
        .prefBase(prefBase),
        .prefLimit(prefLimit),
        .vgaMemRange(priVgaMem),
        .vgaIoRange(priVgaIo),
        .ioWindowHit(priIoWin),
        .memWindowHit(priMemWin),
        .ioLowRegion(priIoLow),
        .isaUpper768(priUpper768)
    );

    logic priVgaIoHit;
    logic priVgaMemHit;
    logic priIsaBlock;
    logic priIoClaim;
    logic priMemClaim;

    // Video path bypasses the ISA bit and all windows
    assign priVgaIoHit = vgaEnable && ioSpaceEnable && priVgaIo;
    assign priVgaMemHit = vgaEnable && memorySpaceEnable && priVgaMem;
    assign priIsaBlock = isaEnable && priIoWin && priIoLow && priUpper768;
    // ISA clear: whole window passes; with video clear only windows decide
    assign priIoClaim = priVgaIoHit ||
                        (ioSpaceEnable && priIoWin && !priIsaBlock);
    assign priMemClaim = priVgaMemHit || (memorySpaceEnable && priMemWin);
    assign priClaim = priValid && (priIsIo ? priIoClaim : priMemClaim);

    // ---------------------------------------------------------------
    // Secondary-to-primary decode
    // ---------------------------------------------------------------
    logic secVgaMem;
    logic secVgaIo;
    logic secIoWin;
    logic secMemWin;
    logic secIoLow;
    logic secUpper768;

    legacy_addr_decode u_sec_decode (
        .addr(secAddr),
        .ioBase(ioBase),
        .ioLimit(ioLimit),
        .memBase(memBase),
        .memLimit(memLimit),
        .prefBase(prefBase),
        .prefLimit(prefLimit),
        .vgaMemRange(secVgaMem),
        .vgaIoRange(secVgaIo),
        .ioWindowHit(secIoWin),
        .memWindowHit(secMemWin),
        .ioLowRegion(secIoLow),
        .isaUpper768(secUpper768)
    );

    logic secIsaPass;
    logic secVgaBlock;
    logic secIoClaim;
    logic secMemClaim;

    // Inside the I/O window only ISA alias space may climb; outside it all but VGA-blocked addresses may
    assign secIsaPass = isaEnable && secIoWin && secIoLow && secUpper768;
    assign secVgaBlock = vgaEnable && (secIsIo ? secVgaIo : secVgaMem);
    assign secIoClaim = !secIoWin || secIsaPass;
    assign secMemClaim = !secMemWin;
    assign secClaim = secValid && busMasterEnable && !secVgaBlock &&
                      (secIsIo ? secIoClaim : secMemClaim);

    // ---------------------------------------------------------------
    // Secondary system-error forwarding
    // ---------------------------------------------------------------
    logic serrMeta_n;
    logic serrSync_n;
    logic serrPrev;
    logic serrLevel;
    logic serrEvent;
    logic serrClear;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            serrMeta_n <= 1'b1;
            serrSync_n <= 1'b1;
            serrPrev <= 1'b0;
        end else begin
            serrMeta_n <= secSerr_n;
            serrSync_n <= serrMeta_n;
            serrPrev <= serrLevel;
        end
    end

    assign serrLevel = !serrSync_n;
    // At most one message per assertion, none while a request is pending; a held pin must not flood the link
    assign serrEvent = serrLevel && !serrPrev && secondarySyserrForwardEnable &&
                       commandSyserrEnable;
    assign serrClear = wrErrStatus && regWdata[ST_SERR_FWD_BIT];

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            serrForwarded <= 1'b0;
            errMsgReq <= 1'b0;
            errMsgFatal <= 1'b0;
        end else begin
            // Set beats a simultaneous write-one-to-clear
            serrForwarded <= serrEvent || (serrForwarded && !serrClear);
            if (serrEvent && !errMsgReq) begin
                errMsgReq <= 1'b1;
                errMsgFatal <= errFatal;
            end else if (errMsgAck) begin
                errMsgReq <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Register read
    // ---------------------------------------------------------------
    logic [DATA_W-1:0] readMux;
    logic [DATA_W-1:0] errStatusWord;

    assign errStatusWord = {29'h0000_0000, errMsgReq, serrForwarded, serrLevel};
    assign readMux = (regAddr == OFS_COMMAND) ? {16'h0000, command} :
                     (regAddr == OFS_BRIDGE_CONTROL) ? {16'h0000, bridgeControl} :
                     (regAddr == OFS_IO_BASE) ? ioBase :
                     (regAddr == OFS_IO_LIMIT) ? ioLimit :
                     (regAddr == OFS_MEM_BASE) ? memBase :
                     (regAddr == OFS_MEM_LIMIT) ? memLimit :
                     (regAddr == OFS_PREF_BASE) ? prefBase :
                     (regAddr == OFS_PREF_LIMIT) ? prefLimit :
                     (regAddr == OFS_ERR_STATUS) ? errStatusWord :
                     (regAddr == OFS_ERR_CONTROL) ? {31'h0000_0000, errFatal} :
                     32'h0000_0000;

    // Data only in the cycle after the read strobe, zero otherwise
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            regRdata <= 32'h0000_0000;
        end else begin
            regRdata <= regRd ? readMux : 32'h0000_0000;
        end
    end

endmodule : bridge_legacy_decode_serr_fwd

//--- bridge_legacy_asserts.sv
// Checker for the legacy decode claims and the error message handshake
`timescale 1ns/100ps
module bridge_legacy_asserts (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [bridge_legacy_pkg::ADDR_W-1:0] regAddr,
    input wire logic [bridge_legacy_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [bridge_legacy_pkg::DATA_W-1:0] regRdata,
    input wire logic priValid,
    input wire logic priIsIo,
    input wire logic [31:0] priAddr,
    input wire logic priClaim,
    input wire logic secValid,
    input wire logic secIsIo,
    input wire logic [31:0] secAddr,
    input wire logic secClaim,
    input wire logic secSerr_n,
    input wire logic errMsgReq,
    input wire logic errMsgFatal,
    input wire logic errMsgAck
);
    import bridge_legacy_pkg::*;
    // ----------
    // Shadow state
    // ----------
    logic [15:0] cmd;
    logic [15:0] bc;
    logic [31:0] ioLo;
    logic [31:0] ioHi;
    logic fatalSel;
    // Rebuilt from port writes only, so a stuck register inside still shows up
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cmd <= COMMAND_RESET;
            bc <= BRIDGE_CONTROL_RESET;
            ioLo <= WINDOW_BASE_RESET;
            ioHi <= WINDOW_LIMIT_RESET;
            fatalSel <= ERR_FATAL_RESET;
        end else if (regWr) begin
            case (regAddr)
                OFS_COMMAND: cmd <= regWdata[15:0] & COMMAND_MASK;
                OFS_BRIDGE_CONTROL: bc <= regWdata[15:0] & BRIDGE_CONTROL_MASK;
                OFS_IO_BASE: ioLo <= regWdata;
                OFS_IO_LIMIT: ioHi <= regWdata;
                OFS_ERR_CONTROL: fatalSel <= regWdata[EC_FATAL_BIT];
                default: ;
            endcase
        end
    end
    function automatic logic vgaIo(input logic [31:0] a);
        vgaIo = (a[31:16] == 16'h0000) && ((a[9:0] >= VGA_IO_A_LO && a[9:0] <= VGA_IO_A_HI)
            || (a[9:0] >= VGA_IO_B_LO && a[9:0] <= VGA_IO_B_HI));
    endfunction : vgaIo
    function automatic logic vgaMem(input logic [31:0] a);
        vgaMem = a >= VGA_MEM_LO && a <= VGA_MEM_HI;
    endfunction : vgaMem
    function automatic logic inIo(input logic [31:0] a);
        inIo = a >= ioLo && a <= ioHi;
    endfunction : inIo
    function automatic logic isaHit(input logic [31:0] a);
        isaHit = inIo(a) && a[31:16] == 16'h0000 && a[9:8] != 2'h0;
    endfunction : isaHit
    wire vga = bc[BC_VGA_BIT];
    wire isa = bc[BC_ISA_BIT];
    wire ioEn = cmd[CMD_IO_SPACE_BIT];
    wire memEn = cmd[CMD_MEM_SPACE_BIT];
    wire busEn = cmd[CMD_BUS_MASTER_BIT];
    wire fwdOn = bc[BC_SYSERR_FWD_BIT] && cmd[CMD_SYSERR_BIT];
    wire priVgaIo = vga && vgaIo(priAddr);
    wire secVga = vga && (secIsIo ? vgaIo(secAddr) : vgaMem(secAddr));
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_vga_mem_down: assert property (
        priValid && !priIsIo && vga && memEn && vgaMem(priAddr) |-> priClaim)
        else $error("video memory access not claimed");
    a_vga_io_down: assert property (
        priValid && priIsIo && ioEn && priVgaIo |-> priClaim)
        else $error("video port access not claimed");
    a_space_gate: assert property (priValid && (priIsIo ? !ioEn : !memEn) |-> !priClaim)
        else $error("claim with space disabled");
    a_vga_up_block: assert property (secValid && secVga |-> !secClaim)
        else $error("video address passed upstream");
    a_isa_down_block: assert property (
        priValid && priIsIo && isa && isaHit(priAddr) && !priVgaIo |-> !priClaim)
        else $error("alias address sent down");
    a_isa_up_pass: assert property (
        secValid && secIsIo && busEn && isa && isaHit(secAddr) && !secVga |-> secClaim)
        else $error("alias address not sent up");
    a_io_window_down: assert property (
        priValid && priIsIo && ioEn && !isa && inIo(priAddr) |-> priClaim)
        else $error("window address not sent down");
    a_fwd_gate: assert property (
        $rose(errMsgReq) |-> $past(fwdOn) && !$past(secSerr_n, 3))
        else $error("message without cause");
    a_fwd_latency: assert property (
        $fell(secSerr_n) && fwdOn && !errMsgReq ##1 (!secSerr_n && fwdOn) [*2] |=> errMsgReq)
        else $error("message late");
    a_req_holds: assert property (
        errMsgReq && !errMsgAck |=> errMsgReq && $stable(errMsgFatal))
        else $error("message dropped early");
    a_ack_drops: assert property (errMsgReq && errMsgAck |=> !errMsgReq)
        else $error("message kept after ack");
    a_msg_kind: assert property ($rose(errMsgReq) |-> errMsgFatal == $past(fatalSel))
        else $error("wrong message kind");
    a_rdata_idle: assert property (!regRd |=> regRdata == '0)
        else $error("read data outside slot");
    c_msg_acked: cover property (errMsgReq && errMsgAck);
    c_isa_up: cover property (secValid && secClaim && isa);
    c_fatal_msg: cover property ($rose(errMsgReq) && errMsgFatal);
endmodule : bridge_legacy_asserts

bind bridge_legacy_decode_serr_fwd bridge_legacy_asserts u_bridge_legacy_asserts (.core_clk, .rstn,
    .regAddr, .regWdata, .regWr, .regRd, .regRdata, .priValid, .priIsIo, .priAddr, .priClaim,
    .secValid, .secIsIo, .secAddr, .secClaim, .secSerr_n, .errMsgReq, .errMsgFatal, .errMsgAck);

//--- link_partner.sv
// Link-side model that takes error messages and acknowledges them
`timescale 1ns/100ps
module link_partner (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic errMsgReq,
    input wire logic errMsgFatal,
    input wire logic [3:0] ackDelay,
    output logic errMsgAck,
    output logic [7:0] msgCount,
    output logic [7:0] fatalCount
);
    logic [3:0] waitCnt;
    // Ack is a one-cycle pulse so one request is never taken twice
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            errMsgAck <= 1'h0;
            waitCnt <= 4'h0;
            msgCount <= 8'h00;
            fatalCount <= 8'h00;
        end else if (errMsgAck || !errMsgReq) begin
            errMsgAck <= 1'h0;
            waitCnt <= 4'h0;
        end else if (waitCnt >= ackDelay) begin
            errMsgAck <= 1'h1;
            msgCount <= msgCount + 8'h01;
            fatalCount <= fatalCount + {7'h00, errMsgFatal};
        end else begin
            waitCnt <= waitCnt + 4'h1;
        end
    end
endmodule : link_partner

//--- testbench.sv
// Self-checking bench for the legacy decode and error forwarding block
`timescale 1ns/100ps
module testbench;
    import bridge_legacy_pkg::*;
    typedef struct packed {
        logic [3:0] cmd;
        logic [3:0] bc;
        logic [1:0] kind;
        logic [31:0] addr;
        logic claim;
    } row_t;
    // Kind: bit1 secondary side, bit0 I/O; windows are I/O 1000h-11FFFh, memory A0000h-AFFFFh
    row_t rows [0:25] = '{
        '{4'h3, 4'h8, 2'h0, 32'h000A0000, 1'h1},
        '{4'h3, 4'h8, 2'h0, 32'h000BFFFF, 1'h1},
        '{4'h3, 4'h8, 2'h0, 32'h000C0000, 1'h0},
        '{4'h3, 4'h8, 2'h1, 32'h000003B0, 1'h1},
        '{4'h3, 4'h8, 2'h1, 32'h000003BB, 1'h1},
        '{4'h3, 4'h8, 2'h1, 32'h000003BC, 1'h0},
        '{4'h3, 4'h8, 2'h1, 32'h00000BDF, 1'h1},
        '{4'h3, 4'h8, 2'h1, 32'h000203C0, 1'h0},
        '{4'h3, 4'hC, 2'h1, 32'h0000FFDF, 1'h1},
        '{4'h3, 4'hC, 2'h1, 32'h000013C0, 1'h1},
        '{4'h2, 4'h8, 2'h1, 32'h000003C0, 1'h0},
        '{4'h1, 4'h8, 2'h0, 32'h000A0000, 1'h0},
        '{4'h3, 4'h0, 2'h0, 32'h000A0000, 1'h1},
        '{4'h3, 4'h0, 2'h0, 32'h000B0000, 1'h0},
        '{4'h3, 4'h0, 2'h1, 32'h000003C0, 1'h0},
        '{4'h7, 4'h8, 2'h2, 32'h000B0000, 1'h0},
        '{4'h7, 4'h8, 2'h3, 32'h000003C0, 1'h0},
        '{4'h7, 4'h0, 2'h2, 32'h000B0000, 1'h1},
        '{4'h3, 4'h4, 2'h1, 32'h00001100, 1'h0},
        '{4'h3, 4'h4, 2'h1, 32'h000013FF, 1'h0},
        '{4'h3, 4'h4, 2'h1, 32'h00001000, 1'h1},
        '{4'h3, 4'h4, 2'h1, 32'h00011100, 1'h1},
        '{4'h3, 4'h0, 2'h1, 32'h00001100, 1'h1},
        '{4'h7, 4'h4, 2'h3, 32'h00001100, 1'h1},
        '{4'h7, 4'h4, 2'h3, 32'h00011100, 1'h0},
        '{4'h7, 4'h4, 2'h3, 32'h00001000, 1'h0}};
    logic core_clk, rstn, regWr, regRd, errMsgReq, errMsgFatal, errMsgAck, secSerr_n;
    logic priValid, priIsIo, priClaim, secValid, secIsIo, secClaim;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWdata, regRdata, rd;
    logic [31:0] priAddr, secAddr;
    logic [3:0] ackDelay;
    logic [7:0] msgCount, fatalCount;
    int miscompares = 0;
    int nChecks = 0;
    int cycles = 0;
    bridge_legacy_decode_serr_fwd u_bridge_legacy_decode_serr_fwd (.core_clk, .rstn, .regAddr,
        .regWdata, .regWr, .regRd, .regRdata, .priValid, .priIsIo, .priAddr, .priClaim, .secValid,
        .secIsIo, .secAddr, .secClaim, .secSerr_n, .errMsgReq, .errMsgFatal, .errMsgAck);
    link_partner u_link_partner (.core_clk, .rstn, .errMsgReq, .errMsgFatal, .ackDelay,
        .errMsgAck, .msgCount, .fatalCount);
    // ----------
    // Tasks
    // ----------
    task automatic wrap_up();
        if (miscompares == 0 && nChecks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask : check
    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWr <= 1'h1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'h0;
    endtask : regWrite
    task automatic regRead(input logic [7:0] a);
        @(posedge core_clk);
        regRd <= 1'h1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'h0;
        @(negedge core_clk);
        rd = regRdata;
    endtask : regRead
    // Pin held low long enough for the two-flop synchroniser to see it
    task automatic serrPulse();
        @(posedge core_clk);
        secSerr_n <= 1'h0;
        repeat (4) @(posedge core_clk);
        secSerr_n <= 1'h1;
        repeat (24) @(posedge core_clk);
    endtask : serrPulse
    // ----------
    // Sequence
    // ----------
    initial begin
        core_clk = 1'h0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            wrap_up();
        end
    end
    initial begin
        {rstn, regWr, regRd, priValid, priIsIo, secValid, secIsIo} = 7'h00;
        {regAddr, regWdata, priAddr, secAddr} = '0;
        secSerr_n = 1'h1;
        ackDelay = 4'hC;
        repeat (12) @(posedge core_clk);
        rstn <= 1'h1;
        regRead(OFS_BRIDGE_CONTROL);
        check(rd, 32'h00000000);
        regRead(8'h80);
        check(rd, 32'h00000000);
        regWrite(OFS_BRIDGE_CONTROL, 32'hFFFFFFFF);
        regRead(OFS_BRIDGE_CONTROL);
        check(rd, {16'h0000, BRIDGE_CONTROL_MASK});
        regWrite(OFS_IO_BASE, 32'h00001000);
        regWrite(OFS_IO_LIMIT, 32'h00011FFF);
        regWrite(OFS_MEM_BASE, 32'h000A0000);
        regWrite(OFS_MEM_LIMIT, 32'h000AFFFF);
        foreach (rows[i]) begin
            regWrite(OFS_COMMAND, {28'h0000000, rows[i].cmd});
            regWrite(OFS_BRIDGE_CONTROL, {28'h0000000, rows[i].bc});
            @(posedge core_clk);
            {secValid, priValid} <= rows[i].kind[1] ? 2'h2 : 2'h1;
            {secIsIo, priIsIo} <= {2{rows[i].kind[0]}};
            {secAddr, priAddr} <= {2{rows[i].addr}};
            @(negedge core_clk);
            check({31'h0, rows[i].kind[1] ? secClaim : priClaim}, {31'h0, rows[i].claim});
        end
        regWrite(OFS_COMMAND, 32'h00000100);
        regWrite(OFS_BRIDGE_CONTROL, 32'h00000000);
        serrPulse();
        regWrite(OFS_COMMAND, 32'h00000000);
        regWrite(OFS_BRIDGE_CONTROL, 32'h00000002);
        serrPulse();
        check({24'h000000, msgCount}, 32'h00000000);
        regWrite(OFS_COMMAND, 32'h00000100);
        // Second pulse lands while the slow partner still holds off its ack
        fork
            serrPulse();
            #60 serrPulse();
        join
        check({24'h000000, msgCount}, 32'h00000001);
        check({24'h000000, fatalCount}, 32'h00000000);
        // Forwarded flag stays set after the message is gone, until written with one
        regRead(OFS_ERR_STATUS);
        check(rd, 32'h00000001 << ST_SERR_FWD_BIT);
        regWrite(OFS_ERR_STATUS, 32'h00000001 << ST_SERR_FWD_BIT);
        regRead(OFS_ERR_STATUS);
        check(rd, 32'h00000000);
        regWrite(OFS_ERR_CONTROL, 32'h00000001);
        ackDelay <= 4'h0;
        serrPulse();
        check({24'h000000, fatalCount}, 32'h00000001);
        rstn <= 1'h0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'h1;
        regRead(OFS_BRIDGE_CONTROL);
        check(rd, 32'h00000000);
        serrPulse();
        check({24'h000000, msgCount}, 32'h00000000);
        wrap_up();
    end
endmodule : testbench
